// ### ope_output_path_enable_ctrl.sv
// enable, status and clock-budget control for six stereo output paths;
// assumes a single-cycle register port and a clock controller that reports
// whether the main system clock runs and how many cycles it spares per sample.
`timescale 1ns/1ps
`default_nettype none
module ope_output_path_enable_ctrl
  import ope_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // register port
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  // clock controller
  input wire logic MAIN_CLK_RUNNING,
  input wire logic [7:0] MAIN_CLK_BUDGET,
  input wire logic [3:0] OUT_RATE_CODE,
  // output paths
  output logic [11:0] CHANNEL_ON,
  output logic [11:0] PATH_MUTE,
  output logic HP_CHARGE_PUMP_EN,
  output logic [3:0] PATH_RATE,
  // sequence events towards the interrupt logic
  output logic [5:0] SEQ_DONE
);
  // ==========================================================
  // state
  logic [11:0] enables;
  logic [11:0] granted;
  logic [11:0] refused;
  logic [11:0] mute;
  logic [11:0] status;
  logic err_flag;
  logic clk_ok;
  logic [7:0] seq_cur;
  logic [3:0] seq_busy;
  logic [3:0] seq_done;
  logic [11:0] req;
  logic [11:0] fit;
  logic [11:0] new_refuse;
  logic [11:0] next_status;
  logic wr_en;
  logic wr_err;
  logic wr_mute;

  // ==========================================================
  // decode and sync
  assign wr_en = REG_WR && (REG_ADDR == ADDR_ENABLES);
  assign wr_err = REG_WR && (REG_ADDR == ADDR_ERROR);
  assign wr_mute = REG_WR && (REG_ADDR == ADDR_MUTE);

  // the running indication comes from another clock's logic
  ope_sync2 #(.W(1)) u_clk_sync
  (
    .clk(CLK),
    .resetn(RESETN),
    .d(MAIN_CLK_RUNNING),
    .q(clk_ok)
  );

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      enables <= ENABLES_RESET;
    end
    else if (wr_en)
    begin
      enables <= REG_WDATA[11:0];
    end
  end

  // ==========================================================
  // clock budget check
  // new requests checked against budget
  assign req = enables & ~granted & ~refused;
  assign fit = clk_ok ? grant_fit(granted & enables, req, MAIN_CLK_BUDGET)
                      : '0;
  assign new_refuse = req & ~fit;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      granted <= '0;
    end
    else
    begin
      granted <= (granted & enables) | fit;
    end
  end

  // refused bits wait for a fresh enable write, no retry storm
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      refused <= '0;
    end
    else if (wr_en)
    begin
      refused <= '0;
    end
    else
    begin
      refused <= (refused & enables) | new_refuse;
    end
  end

  // sticky underclock flag, a new refusal beats the clear
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      err_flag <= 1'b0;
    end
    else if (|new_refuse)
    begin
      err_flag <= 1'b1;
    end
    else if (wr_err && REG_WDATA[ERR_BIT])
    begin
      err_flag <= 1'b0;
    end
  end

  // ==========================================================
  // pop-suppressed sequencers for paths 1 to 4
  ope_seq_if seq_bus[NUM_SEQ] ();

  generate
    for (genvar g = 0; g < NUM_SEQ; g++)
    begin : g_seq
      // grant change launches the path sequence
      assign seq_bus[g].target = granted[2*g +: 2];
      assign seq_cur[2*g +: 2] = seq_bus[g].current;
      assign seq_busy[g] = seq_bus[g].busy;
      assign seq_done[g] = seq_bus[g].done;
      ope_pop_seq u_seq
      (
        .clk(CLK),
        .resetn(RESETN),
        .bus(seq_bus[g])
      );
    end
  endgenerate

  // ==========================================================
  // status and path outputs
  // analogue status follows the sequencers, digital follows grant
  assign next_status = {granted[11:DIG_LO], seq_cur};

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      status <= STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

  assign CHANNEL_ON = status;

  // mute register, held high from reset until software clears it
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      mute <= MUTE_RESET;
    end
    else if (wr_mute)
    begin
      mute <= REG_WDATA[11:0];
    end
  end

  // a channel that is not on stays muted
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PATH_MUTE <= MUTE_RESET;
    end
    else
    begin
      PATH_MUTE <= mute | ~next_status;
    end
  end

  // pump runs while any headphone channel is granted, ramping or on
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      HP_CHARGE_PUMP_EN <= 1'b0;
    end
    else
    begin
      HP_CHARGE_PUMP_EN <= |{granted[HP_CH-1:0], status[HP_CH-1:0],
                             seq_busy[2:0]};
    end
  end

  // shared rate only taken while every path is off, avoiding glitches
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PATH_RATE <= RATE_RESET;
    end
    else if (status == STATUS_RESET)
    begin
      PATH_RATE <= OUT_RATE_CODE;
    end
  end

  // completion events, digital paths finish as soon as status moves
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SEQ_DONE <= '0;
    end
    else
    begin
      SEQ_DONE[3:0] <= seq_done;
      SEQ_DONE[4] <= (next_status[9:8] != status[9:8]);
      SEQ_DONE[5] <= (next_status[11:10] != status[11:10]);
    end
  end

  // ==========================================================
  // register read port
  // status split over two registers
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      REG_RDATA <= '0;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      REG_RDATA <= '0;
      if (REG_RD)
      begin
        unique case (REG_ADDR)
          ADDR_ENABLES: REG_RDATA <= {4'h0, enables};
          ADDR_STATUS: REG_RDATA <= {4'h0, status & STATUS_MASK};
          ADDR_RAW_STATUS: REG_RDATA <= {4'h0, status & RAW_STATUS_MASK};
          ADDR_ERROR: REG_RDATA <= {15'h0000, err_flag};
          ADDR_MUTE: REG_RDATA <= {4'h0, mute};
          default: REG_RDATA <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  refuse_sets_err_a: assert property (
    |new_refuse |=> err_flag)
    else $error("refusal did not raise the error flag");
  running_kept_a: assert property (
    |new_refuse |=> ((granted & $past(granted & enables)) ==
                     $past(granted & enables)))
    else $error("refusal disturbed a running channel");
  clock_off_a: assert property (
    !clk_ok |=> ((granted & ~$past(granted)) == '0))
    else $error("channel granted without main clock");
  digital_off_a: assert property (
    $fell(enables[DIG_LO]) |-> ##2 !CHANNEL_ON[DIG_LO])
    else $error("digital channel stayed on after disable");
  muted_when_off_a: assert property (
    (~CHANNEL_ON & ~PATH_MUTE) == '0)
    else $error("channel unmuted while off");
  pump_follows_a: assert property (
    (|CHANNEL_ON[HP_CH-1:0]) |=> HP_CHARGE_PUMP_EN)
    else $error("charge pump off while headphone path on");
  digital_event_a: assert property (
    $changed(CHANNEL_ON[11:10]) |-> SEQ_DONE[5])
    else $error("path 6 change without completion event");
  read_answer_a: assert property (
    REG_RD && (REG_ADDR == ADDR_RAW_STATUS) |=>
      REG_RVALID && (REG_RDATA[5:0] == $past(status[5:0])))
    else $error("raw status read wrong");
endmodule
`default_nettype wire

// ### ope_pkg.sv
// constants, register map and shared functions of the output path enable
// control; assumes a 16-bit register space reached by word address.
//
// How it works
// - twelve enable bits, path 6 left at bit 11 down to path 1 right at bit 0.
// - enable and status bits reset to zero and a one asks for the channel.
// - every path leaves reset muted whatever its enable bit says.
// - the headphone charge pump turns on by itself while paths 1 to 3 need it.
// - changing an enable of paths 1 to 4 starts a pop-suppressed sequence.
// - the end of every enable or disable sequence is sent out as an event.
// - each enable request is checked against the clock budget and refused if short.
// - a refused request leaves every running path untouched.
// - status shows real channel state, paths 6-4 in one register, 3-1 in another.
// - all paths take mixer samples at one shared output rate.
package ope_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] ADDR_ENABLES = 16'h0400;
  localparam logic [15:0] ADDR_STATUS = 16'h0401;
  localparam logic [15:0] ADDR_RAW_STATUS = 16'h0406;
  localparam logic [15:0] ADDR_ERROR = 16'h0407;
  localparam logic [15:0] ADDR_MUTE = 16'h0408;

  // ==========================================================
  // field layout and reset values
  localparam int NUM_CH = 12;
  localparam int NUM_SEQ = 4;
  localparam int ANALOG_CH = 8;
  localparam int HP_CH = 6;
  localparam int DIG_LO = 8;
  localparam int ERR_BIT = 0;
  localparam logic [11:0] ENABLES_RESET = 12'h000;
  localparam logic [11:0] STATUS_RESET = 12'h000;
  localparam logic [11:0] MUTE_RESET = 12'hfff;
  localparam logic [11:0] STATUS_MASK = 12'hfc0;
  localparam logic [11:0] RAW_STATUS_MASK = 12'h03f;
  localparam logic [3:0] RATE_RESET = 4'h0;

  // ==========================================================
  // clock budget: cycles per sample each channel consumes
  localparam logic [8:0] ANALOG_COST = 9'h010;
  localparam logic [8:0] DIGITAL_COST = 9'h008;

  // ==========================================================
  // timing: pop-suppressed ramp length
  localparam int SEQ_TIME_NS = 1000;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int SEQ_CYCLES = (SEQ_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  // cost of one channel, analogue channels need the dac as well
  function automatic logic [8:0] ch_cost(input int i);
    return (i < ANALOG_CH) ? ANALOG_COST : DIGITAL_COST;
  endfunction

  // grant requests in bit order, each one that still fits beside the running load
  function automatic logic [11:0] grant_fit(input logic [11:0] run,
                                            input logic [11:0] req,
                                            input logic [7:0] budget);
    logic [11:0] g;
    logic [8:0] load;
    g = '0;
    load = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (run[i])
      begin
        load = load + ch_cost(i);
      end
    end
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (req[i] && (load + ch_cost(i) <= {1'b0, budget}))
      begin
        g[i] = 1'b1;
        load = load + ch_cost(i);
      end
    end
    return g;
  endfunction
endpackage

// ### ope_seq_if.sv
// handshake between the enable controller and one path sequencer;
// assumes both ends share the controller clock.
`timescale 1ns/1ps
`default_nettype none
interface ope_seq_if;
  logic [1:0] target;
  logic [1:0] current;
  logic busy;
  logic done;
  modport ctrl (output target, input current, input busy, input done);
  modport seq (input target, output current, output busy, output done);
endinterface
`default_nettype wire

// ### ope_sync2.sv
// two-stage synchroniser for levels arriving from outside the clock domain;
// assumes the level is stable for several cycles.
`timescale 1ns/1ps
`default_nettype none
module ope_sync2 #(parameter int W = 1)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ### ope_pop_seq.sv
// pop-suppressed ramp for one stereo analogue path; assumes the target
// is held steady by the controller while busy is high.
`timescale 1ns/1ps
`default_nettype none
module ope_pop_seq
  import ope_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // controller side
  ope_seq_if.seq bus
);
  typedef enum logic {SEQ_IDLE, SEQ_RAMP} ope_seq_e;
  localparam int SEQ_WAIT = SEQ_CYCLES;
  localparam logic [7:0] LAST_CNT = 8'(SEQ_CYCLES - 1);
  ope_seq_e state;
  logic [7:0] cnt;
  logic [1:0] tgt;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= SEQ_IDLE;
      cnt <= '0;
      tgt <= '0;
    end
    else
    begin
      unique case (state)
        SEQ_IDLE:
        begin
          cnt <= '0;
          if (bus.target != bus.current)
          begin
            tgt <= bus.target;
            state <= SEQ_RAMP;
          end
        end
        SEQ_RAMP:
        begin
          cnt <= cnt + 8'h01;
          if (cnt == LAST_CNT)
          begin
            state <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // channel state and completion pulse change together
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus.current <= '0;
      bus.done <= 1'b0;
    end
    else
    begin
      bus.done <= (state == SEQ_RAMP) && (cnt == LAST_CNT);
      if ((state == SEQ_RAMP) && (cnt == LAST_CNT))
      begin
        bus.current <= tgt;
      end
    end
  end

  assign bus.busy = (state == SEQ_RAMP);

  sequence ramp_start_s;
    $rose(bus.busy);
  endsequence
  sequence ramp_end_s;
    ##SEQ_WAIT bus.done;
  endsequence
  ramp_length_a: assert property (@(posedge clk) disable iff (!resetn)
    ramp_start_s |-> ramp_end_s)
    else $error("ramp did not finish on time");
  state_at_done_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(bus.current) |-> bus.done && !bus.busy)
    else $error("channel state moved without completion");
endmodule
`default_nettype wire

// ### ope_output_path_enable_ctrl_tb_top.sv
// self-checking bench for the output path enable control block
// assumes the design files are compiled first; no model sits beyond the ports
`timescale 1ns/1ps
`default_nettype none
module ope_output_path_enable_ctrl_tb_top
  import ope_pkg::*;
;
  // ==========================================================
  // stimulus and observation
  logic clk, resetn, reg_wr, reg_rd, clk_run;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic seen_clr;
  logic reg_rvalid, pump;
  logic [7:0] budget;
  logic [3:0] rate_code, path_rate;
  logic [11:0] channel_on, path_mute;
  logic [5:0] seq_done, seq_seen;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  ope_output_path_enable_ctrl u_dut (.CLK(clk), .RESETN(resetn),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .MAIN_CLK_RUNNING(clk_run), .MAIN_CLK_BUDGET(budget),
    .OUT_RATE_CODE(rate_code), .CHANNEL_ON(channel_on),
    .PATH_MUTE(path_mute), .HP_CHARGE_PUMP_EN(pump),
    .PATH_RATE(path_rate), .SEQ_DONE(seq_done));

  // ==========================================================
  // clock and hang guard; ceiling is about twenty times the planned run
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // done pulses last one cycle, so collect them sticky here; one driver only
  always @(posedge clk)
  begin
    if (!resetn || seen_clr)
      seq_seen <= 6'h00;
    else
      seq_seen <= seq_seen | seq_done;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // ==========================================================
  // tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  // data is valid in the cycle after the request edge
  task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    cmp({15'h0, reg_rvalid}, 16'h0001, "read valid");
    cmp(reg_rdata, exp, "read data");
  endtask

  // ramps take about 200 cycles, so the wait is bounded a little above
  task automatic wait_on(input logic [11:0] exp, input int max);
    int n;
    n = 0;
    while (channel_on !== exp && n < max)
    begin
      @(posedge clk);
      #1 n++;
    end
    cmp({4'h0, channel_on}, {4'h0, exp}, "channel state");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial
  begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    clk_run = 1'b1; // main clock first, no async-clock routes
    budget = 8'hff;
    rate_code = 4'h3; // one synchronous rate, no converter needed
    seen_clr = 1'b0;
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    cmp({4'h0, path_mute}, 16'h0fff, "mute after reset");
    cmp({4'h0, channel_on}, 16'h0000, "off after reset");
    reg_read(ADDR_ENABLES, 16'h0000);
    reg_read(ADDR_STATUS, 16'h0000);
    reg_read(ADDR_RAW_STATUS, 16'h0000);
    reg_read(16'h0500, 16'h0000);
    reg_write(ADDR_STATUS, 16'h0fff);
    reg_read(ADDR_STATUS, 16'h0000);
    cmp({12'h0, path_rate}, 16'h0003, "shared rate");
    $display("test reset done");

    // digital path 5 right, then path 1 pair with its ramp
    reg_write(ADDR_ENABLES, 16'h0100);
    wait_on(12'h100, 10);
    cmp({10'h0, seq_seen | seq_done}, 16'h0010, "path5 done");
    reg_write(ADDR_ENABLES, 16'h0103);
    wait_on(12'h103, 260);
    cmp({15'h0, pump}, 16'h0001, "pump on");
    cmp({10'h0, seq_seen | seq_done}, 16'h0011, "path1 done");
    reg_read(ADDR_RAW_STATUS, 16'h0003);
    reg_write(ADDR_MUTE, 16'h0000);
    @(posedge clk);
    #1 cmp({4'h0, path_mute}, 16'h0efc, "unmuted live only");
    $display("test enable done");

    // load 40; budget 48 fits one digital channel exactly, no analogue
    budget = 8'd48;
    reg_write(ADDR_ENABLES, 16'h030f);
    wait_on(12'h303, 10);
    repeat (220) @(posedge clk);
    #1 cmp({4'h0, channel_on}, 16'h0303, "no late grant");
    reg_read(ADDR_STATUS, 16'h0300);
    reg_read(ADDR_RAW_STATUS, 16'h0003);
    reg_read(ADDR_ERROR, 16'h0001);
    reg_write(ADDR_ERROR, 16'h0001);
    reg_read(ADDR_ERROR, 16'h0000);
    $display("test underclock done");

    // stopped clock refuses new requests yet keeps running paths
    budget = 8'hff;
    clk_run = 1'b0;
    repeat (4) @(posedge clk);
    reg_write(ADDR_ENABLES, 16'h0703);
    repeat (10) @(posedge clk);
    #1 cmp({4'h0, channel_on}, 16'h0303, "stopped clock");
    reg_read(ADDR_ERROR, 16'h0001);
    clk_run = 1'b1;
    repeat (4) @(posedge clk);
    // path 2 retried too, its ramp now fits the restored budget
    reg_write(ADDR_ENABLES, 16'h070f);
    wait_on(12'h70f, 260);
    $display("test clock stop done");

    // mute first, then switch every path off
    reg_write(ADDR_MUTE, 16'h0fff);
    seen_clr = 1'b1;
    @(posedge clk);
    #1 seen_clr = 1'b0;
    reg_write(ADDR_ENABLES, 16'h0000);
    wait_on(12'h000, 260);
    @(posedge clk);
    #1 cmp({10'h0, seq_seen | seq_done}, 16'h0033, "off done");
    cmp({15'h0, pump}, 16'h0000, "pump off");
    cmp({4'h0, path_mute}, 16'h0fff, "muted when off");
    reg_read(ADDR_STATUS, 16'h0000);
    // main clock stops only once every enable is already low
    clk_run = 1'b0;
    reg_read(ADDR_ENABLES, 16'h0000);
    $display("test disable done");
    wrap_up();
  end
endmodule
`default_nettype wire
